// ==== core/adcmt_ctrl.sv ====
// adcmt_ctrl: converter reset, clock gate, timing modes, triggers and window check
// assumes an AXI4-Lite master, trigger inputs as one-cycle pulses and an
// external converter core that presents its code on analog_code
`timescale 1ns/1ps
module adcmt_ctrl #(
  parameter int ADDR_W = 6,
  parameter int RES_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // hardware trigger sources
  input wire logic timer_ch1_irq,
  input wire logic elc_event,
  input wire logic rtc_irq,
  input wire logic interval_timer_irq,
  // converter core
  input wire logic [RES_W-1:0] analog_code,
  output logic converter_reset_hold,
  output logic converter_clock_gate,
  output logic comparator_enable,
  output logic channel_select_mode,
  output logic sample_active,
  output logic conversion_busy,
  // events
  output logic conversion_end_irq,
  output logic irq
);

  typedef struct packed {
    logic [7:0] prr;
    logic [7:0] per;
    logic [7:0] converter_timing_mode;
    logic [7:0] converter_trigger_mode;
    logic [7:0] rcfg;
    logic [RES_W-1:0] ul;
    logic [RES_W-1:0] ll;
    logic [RES_W-1:0] res;
    logic [7:0] ists;
    logic [7:0] imsk;
    adcmt_pkg::adcmt_state_t fsm;
    logic [5:0] stab_cnt;
    logic [7:0] conv_cnt;
    logic [RES_W-1:0] sample;
    logic end_pulse;
    logic [15:0] age;
    logic aw_full;
    logic [ADDR_W-1:0] awaddr;
    logic w_full;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } adcmt_regs_t;

  // converter registers back to reset, bus and gate registers untouched
  function automatic adcmt_regs_t conv_reset(input adcmt_regs_t s);
    adcmt_regs_t r;
    r = s;
    r.converter_timing_mode = '0;
    r.converter_trigger_mode = '0;
    r.rcfg = '0;
    r.ul = RES_W'(adcmt_pkg::RST_UPPER);
    r.ll = RES_W'(adcmt_pkg::RST_LOWER);
    r.res = '0;
    r.fsm = adcmt_pkg::S_IDLE;
    r.stab_cnt = '0;
    r.conv_cnt = '0;
    r.sample = '0;
    r.end_pulse = 1'b0;
    r.age = '0;
    return r;
  endfunction

  adcmt_regs_t st;
  adcmt_regs_t next_st;
  logic hold;
  logic gate;
  logic live;
  logic run;
  logic hw_mode;
  logic hw_wait;
  logic trig_sel;
  logic start_evt;
  logic tick;
  logic last_tick;
  logic win_hit;
  logic wr_fire;
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic [1:0] tmode;
  logic [2:0] dcode;
  logic [5:0] stab_len;
  logic [7:0] conv_len;
  logic [7:0] samp_len;
  logic [7:0] set_bits;
  logic [7:0] wbyte;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  assign hold = st.prr[adcmt_pkg::BIT_RESET_HOLD];
  assign gate = st.per[adcmt_pkg::BIT_CLOCK_GATE];
  assign live = !hold && gate;
  assign run = st.converter_timing_mode[adcmt_pkg::BIT_RUN];
  assign tmode = st.converter_timing_mode[adcmt_pkg::LSB_TMODE +: 2];
  assign dcode = st.converter_timing_mode[adcmt_pkg::LSB_DIV +: 3];
  assign hw_mode = st.converter_trigger_mode[adcmt_pkg::LSB_TRIG + 1];
  assign hw_wait = hw_mode && st.converter_trigger_mode[adcmt_pkg::LSB_TRIG];
  assign stab_len = adcmt_pkg::stab_clocks(tmode, dcode == adcmt_pkg::DIV_CODE_UNDIV);
  assign conv_len = adcmt_pkg::conv_clocks(tmode);
  assign samp_len = adcmt_pkg::samp_clocks(tmode);
  assign last_tick = tick && (st.conv_cnt + 8'd1 == conv_len);

  always_comb begin
    unique case (st.converter_trigger_mode[adcmt_pkg::LSB_TSEL +: 2])
      2'h0: trig_sel = timer_ch1_irq;
      2'h1: trig_sel = elc_event;
      2'h2: trig_sel = rtc_irq;
      2'h3: trig_sel = interval_timer_irq;
    endcase
  end

  // software mode runs on the level of the run bit
  assign start_evt = hw_mode ? trig_sel : 1'b1;

  // window test on the code about to be stored
  always_comb begin
    if (st.rcfg[adcmt_pkg::BIT_RANGE_POL]) begin
      win_hit = (st.sample < st.ll) || (st.sample > st.ul);
    end else begin
      win_hit = (st.sample >= st.ll) && (st.sample <= st.ul);
    end
  end

  adcmt_clkdiv #(
    .CNT_W(6)
  ) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(gate && !hold && st.fsm == adcmt_pkg::S_CONV),
    .div_code(dcode),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // bus handshakes
  // ---------------------------------------------------------------
  assign s_axi_awready = !st.aw_full && !st.bvalid;
  assign s_axi_wready = !st.w_full && !st.bvalid;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = {24'h000000, st.rdata};
  assign wr_fire = st.aw_full && st.w_full && !st.bvalid;
  assign wr_idx = st.awaddr[5:2];
  assign rd_idx = s_axi_araddr[5:2];
  assign wbyte = st.wstrb0 ? st.wdata : 8'h00;

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign converter_reset_hold = hold;
  assign converter_clock_gate = gate;
  assign comparator_enable = st.converter_timing_mode[adcmt_pkg::BIT_CMP_EN];
  assign channel_select_mode = st.converter_timing_mode[adcmt_pkg::BIT_SCAN];
  assign sample_active = (st.fsm == adcmt_pkg::S_CONV) && (st.conv_cnt < samp_len);
  assign conversion_busy = (st.fsm != adcmt_pkg::S_IDLE);
  assign conversion_end_irq = st.end_pulse;
  assign irq = |(st.ists & st.imsk);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    set_bits = 8'h00;
    next_st.end_pulse = 1'b0;

    // write channel capture, either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_full = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_full = 1'b1;
      next_st.wdata = s_axi_wdata[7:0];
      next_st.wstrb0 = s_axi_wstrb[0];
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    // conversion sequencer, frozen while the clock gate is off
    if (live) begin
      next_st.age = st.age + 16'd1;
      unique case (st.fsm)
        adcmt_pkg::S_IDLE: begin
          if (run && comparator_enable && start_evt) begin
            next_st.age = '0;
            next_st.stab_cnt = '0;
            next_st.conv_cnt = '0;
            if (hw_mode && !hw_wait) begin
              next_st.fsm = adcmt_pkg::S_CONV;
            end else begin
              next_st.fsm = adcmt_pkg::S_STAB;
            end
          end
        end
        adcmt_pkg::S_STAB: begin
          next_st.stab_cnt = st.stab_cnt + 6'd1;
          if (st.stab_cnt + 6'd1 == stab_len) begin
            next_st.fsm = adcmt_pkg::S_CONV;
            next_st.age = '0;
          end
        end
        adcmt_pkg::S_CONV: begin
          if (tick) begin
            next_st.conv_cnt = st.conv_cnt + 8'd1;
          end
          if (tick && st.conv_cnt + 8'd1 == samp_len) begin
            next_st.sample = analog_code;
          end
          if (last_tick) begin
            next_st.age = '0;
            next_st.conv_cnt = '0;
            next_st.fsm = adcmt_pkg::S_IDLE;
            if (win_hit) begin
              next_st.res = st.sample;
              next_st.end_pulse = 1'b1;
              set_bits[adcmt_pkg::BIT_IRQ_END] = 1'b1;
            end
            if (!hw_mode && st.converter_trigger_mode[adcmt_pkg::BIT_ONE_SHOT]) begin
              next_st.converter_timing_mode[adcmt_pkg::BIT_RUN] = 1'b0;
            end
            if (hw_mode && !st.converter_trigger_mode[adcmt_pkg::BIT_ONE_SHOT]) begin
              next_st.fsm = adcmt_pkg::S_CONV;
            end
          end
        end
        default: next_st.fsm = adcmt_pkg::S_IDLE;
      endcase
      // hardware trigger while busy is dropped and flagged
      if (hw_mode && run && trig_sel && st.fsm != adcmt_pkg::S_IDLE) begin
        set_bits[adcmt_pkg::BIT_IRQ_OVR] = 1'b1;
      end
      if (!run || !comparator_enable) begin
        next_st.fsm = adcmt_pkg::S_IDLE;
      end
    end

    // register writes
    if (wr_fire) begin
      next_st.aw_full = 1'b0;
      next_st.w_full = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = (wr_idx > adcmt_pkg::IDX_IRQ_MASK) ?
                      adcmt_pkg::RESP_SLVERR : adcmt_pkg::RESP_OKAY;
      if (st.wstrb0) begin
        unique case (wr_idx)
          adcmt_pkg::IDX_RESET_CTRL: next_st.prr = wbyte & adcmt_pkg::WMASK_RESET_CTRL;
          adcmt_pkg::IDX_CLOCK_EN: next_st.per = wbyte & adcmt_pkg::WMASK_CLOCK_EN;
          adcmt_pkg::IDX_TIMING: if (live) next_st.converter_timing_mode = wbyte;
          adcmt_pkg::IDX_TRIGGER: if (live) next_st.converter_trigger_mode = wbyte & adcmt_pkg::WMASK_TRIGGER;
          adcmt_pkg::IDX_RANGE_CFG: if (live) next_st.rcfg = wbyte & adcmt_pkg::WMASK_RANGE_CFG;
          adcmt_pkg::IDX_UPPER: if (live) next_st.ul = RES_W'(wbyte);
          adcmt_pkg::IDX_LOWER: if (live) next_st.ll = RES_W'(wbyte);
          adcmt_pkg::IDX_IRQ_MASK: next_st.imsk = wbyte & adcmt_pkg::WMASK_IRQ;
          default: ;
        endcase
      end
    end

    // sticky status: set wins over write-one-to-clear
    if (wr_fire && wr_idx == adcmt_pkg::IDX_IRQ_STATUS) begin
      next_st.ists = (st.ists & ~(wbyte & adcmt_pkg::WMASK_IRQ)) | set_bits;
    end else begin
      next_st.ists = st.ists | set_bits;
    end

    // register reads
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = adcmt_pkg::RESP_OKAY;
      unique case (rd_idx)
        adcmt_pkg::IDX_RESET_CTRL: next_st.rdata = st.prr;
        adcmt_pkg::IDX_CLOCK_EN: next_st.rdata = st.per;
        adcmt_pkg::IDX_TIMING: next_st.rdata = st.converter_timing_mode;
        adcmt_pkg::IDX_TRIGGER: next_st.rdata = st.converter_trigger_mode;
        adcmt_pkg::IDX_RANGE_CFG: next_st.rdata = st.rcfg;
        adcmt_pkg::IDX_UPPER: next_st.rdata = 8'(st.ul);
        adcmt_pkg::IDX_LOWER: next_st.rdata = 8'(st.ll);
        adcmt_pkg::IDX_RESULT: next_st.rdata = 8'(st.res);
        adcmt_pkg::IDX_IRQ_STATUS: next_st.rdata = st.ists;
        adcmt_pkg::IDX_IRQ_MASK: next_st.rdata = st.imsk;
        default: begin
          next_st.rdata = 8'h00;
          next_st.rresp = adcmt_pkg::RESP_SLVERR;
        end
      endcase
    end

    // converter held in reset
    if (next_st.prr[adcmt_pkg::BIT_RESET_HOLD]) begin
      next_st = conv_reset(next_st);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= conv_reset('0);
      st.prr <= adcmt_pkg::RST_RESET_CTRL;
      st.per <= adcmt_pkg::RST_CLOCK_EN;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  hold_clears_a: assert property (hold |-> st.fsm == adcmt_pkg::S_IDLE && st.res == '0)
    else $error("converter active while held in reset");
  gate_freeze_a: assert property (!gate && !hold && $past(!gate) |-> $stable(st.fsm) && !tick)
    else $error("sequencer moved with clock gated");
  scan_mode_a: assert property (wr_fire && st.wstrb0 && wr_idx == adcmt_pkg::IDX_TIMING && live
    |=> channel_select_mode == $past(st.wdata[adcmt_pkg::BIT_SCAN]))
    else $error("channel mode not taken from write");
  stab_len_a: assert property ($past(st.fsm) == adcmt_pkg::S_STAB && st.fsm == adcmt_pkg::S_CONV
    && $past(live) |-> $past(st.age) + 16'd1 == 16'($past(stab_len)))
    else $error("stabilization wait has wrong length");
  conv_len_a: assert property (last_tick && live
    |-> st.age + 16'd1 == 16'(conv_len) * 16'(adcmt_pkg::div_ratio(dcode)))
    else $error("conversion time does not match count");
  samp_end_a: assert property (sample_active && tick && st.conv_cnt + 8'd1 == samp_len && live
    |=> !sample_active)
    else $error("sampling window wrong length");
  nowait_a: assert property (live && run && comparator_enable && hw_mode && !hw_wait
    && trig_sel && st.fsm == adcmt_pkg::S_IDLE |=> st.fsm == adcmt_pkg::S_CONV)
    else $error("no-wait trigger did not start conversion");
  itsel_a: assert property (live && run && comparator_enable && hw_wait && interval_timer_irq
    && st.converter_trigger_mode[1:0] == 2'h3 && st.fsm == adcmt_pkg::S_IDLE |=> st.fsm == adcmt_pkg::S_STAB)
    else $error("selected trigger source ignored");
  window_a: assert property (conversion_end_irq |-> (st.rcfg[adcmt_pkg::BIT_RANGE_POL] ?
    (st.res < st.ll || st.res > st.ul) : (st.res >= st.ll && st.res <= st.ul)))
    else $error("end interrupt outside window");
  oneshot_a: assert property (last_tick && live && run && hw_wait
    && st.converter_trigger_mode[adcmt_pkg::BIT_ONE_SHOT] |=> st.fsm == adcmt_pkg::S_IDLE && run)
    else $error("hardware one-shot did not return to wait");
  irq_level_a: assert property (conversion_end_irq && st.imsk[adcmt_pkg::BIT_IRQ_END]
    |-> irq ##1 irq)
    else $error("unmasked end event did not raise irq");

  sw_conv_c: cover property (!hw_mode && last_tick && live);
  hw_wait_c: cover property (hw_wait && st.fsm == adcmt_pkg::S_STAB ##1 st.fsm == adcmt_pkg::S_CONV);
  end_irq_c: cover property (conversion_end_irq && irq);
  overrun_c: cover property (set_bits[adcmt_pkg::BIT_IRQ_OVR]);

endmodule // adcmt_ctrl

// ==== pkg/adcmt_pkg.sv ====
// adcmt_pkg: constants, types and decode functions of the converter control block
// assumes a 200 MHz aclk and register access over a 32-bit AXI4-Lite slave
//
// Functional notes
// - reset-hold bit keeps converter in reset
// - clock-gate bit stops or supplies converter clock
// - mode bit picks select or scan mode
// - divider code gives ratios 32..1
// - stabilization wait length set by timing mode
// - conversion length and sampling per timing mode
// - total time equals wait plus clocks
// - trigger field picks software or hardware modes
// - end interrupt only for result passing the window test
// - trigger source select picks four sources
// - range-check bit inverts the window test
package adcmt_pkg;

  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [3:0] IDX_RESET_CTRL = 4'h0;
  localparam logic [3:0] IDX_CLOCK_EN = 4'h1;
  localparam logic [3:0] IDX_TIMING = 4'h2;
  localparam logic [3:0] IDX_TRIGGER = 4'h3;
  localparam logic [3:0] IDX_RANGE_CFG = 4'h4;
  localparam logic [3:0] IDX_UPPER = 4'h5;
  localparam logic [3:0] IDX_LOWER = 4'h6;
  localparam logic [3:0] IDX_RESULT = 4'h7;
  localparam logic [3:0] IDX_IRQ_STATUS = 4'h8;
  localparam logic [3:0] IDX_IRQ_MASK = 4'h9;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_RESET_HOLD = 5;
  localparam int BIT_CLOCK_GATE = 5;
  localparam int BIT_RUN = 7;
  localparam int BIT_SCAN = 6;
  localparam int LSB_DIV = 3;
  localparam int LSB_TMODE = 1;
  localparam int BIT_CMP_EN = 0;
  localparam int LSB_TRIG = 6;
  localparam int BIT_ONE_SHOT = 5;
  localparam int LSB_TSEL = 0;
  localparam int BIT_RANGE_POL = 3;
  localparam int BIT_IRQ_END = 0;
  localparam int BIT_IRQ_OVR = 1;

  // ---------------------------------------------------------------
  // reset values and writable bits
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_RESET_CTRL = 8'h00;
  localparam logic [7:0] RST_CLOCK_EN = 8'h00;
  localparam logic [7:0] RST_UPPER = 8'hFF;
  localparam logic [7:0] RST_LOWER = 8'h00;
  localparam logic [7:0] WMASK_RESET_CTRL = 8'h20;
  localparam logic [7:0] WMASK_CLOCK_EN = 8'h20;
  localparam logic [7:0] WMASK_TRIGGER = 8'hE3;
  localparam logic [7:0] WMASK_RANGE_CFG = 8'h08;
  localparam logic [7:0] WMASK_IRQ = 8'h03;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // timing counts
  // ---------------------------------------------------------------
  localparam logic [5:0] STAB_M0 = 6'd4;
  localparam logic [5:0] STAB_M0_UNDIV = 6'd2;
  localparam logic [5:0] STAB_M1 = 6'd58;
  localparam logic [5:0] STAB_M1_UNDIV = 6'd29;
  localparam logic [5:0] STAB_M2 = 6'd15;
  localparam logic [5:0] STAB_M3 = 6'd8;
  localparam logic [7:0] CONV_M0 = 8'd41;
  localparam logic [7:0] CONV_M1 = 8'd53;
  localparam logic [7:0] CONV_M2 = 8'd63;
  localparam logic [7:0] CONV_M3 = 8'd217;
  localparam logic [7:0] SAMP_M0 = 8'd11;
  localparam logic [7:0] SAMP_M1 = 8'd23;
  localparam logic [7:0] SAMP_M2 = 8'd33;
  localparam logic [7:0] SAMP_M3 = 8'd187;
  localparam logic [2:0] DIV_CODE_UNDIV = 3'h7;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_STAB = 3'b010,
    S_CONV = 3'b100
  } adcmt_state_t;

  // ---------------------------------------------------------------
  // decode functions
  // ---------------------------------------------------------------
  function automatic logic [5:0] div_ratio(input logic [2:0] code);
    logic [5:0] r;
    r = 6'd1;
    unique case (code)
      3'h0: r = 6'd32;
      3'h1: r = 6'd16;
      3'h2: r = 6'd8;
      3'h3: r = 6'd6;
      3'h4: r = 6'd5;
      3'h5: r = 6'd4;
      3'h6: r = 6'd2;
      3'h7: r = 6'd1;
    endcase
    return r;
  endfunction

  function automatic logic [5:0] stab_clocks(input logic [1:0] mode, input logic undiv);
    logic [5:0] s;
    s = STAB_M3;
    unique case (mode)
      2'h0: s = undiv ? STAB_M0_UNDIV : STAB_M0;
      2'h1: s = undiv ? STAB_M1_UNDIV : STAB_M1;
      2'h2: s = STAB_M2;
      2'h3: s = STAB_M3;
    endcase
    return s;
  endfunction

  function automatic logic [7:0] conv_clocks(input logic [1:0] mode);
    logic [7:0] c;
    c = CONV_M3;
    unique case (mode)
      2'h0: c = CONV_M0;
      2'h1: c = CONV_M1;
      2'h2: c = CONV_M2;
      2'h3: c = CONV_M3;
    endcase
    return c;
  endfunction

  function automatic logic [7:0] samp_clocks(input logic [1:0] mode);
    logic [7:0] c;
    c = SAMP_M3;
    unique case (mode)
      2'h0: c = SAMP_M0;
      2'h1: c = SAMP_M1;
      2'h2: c = SAMP_M2;
      2'h3: c = SAMP_M3;
    endcase
    return c;
  endfunction

endpackage

// ==== core/adcmt_clkdiv.sv ====
// adcmt_clkdiv: conversion clock divider, one tick per conversion clock
// assumes run is low outside conversion so each conversion starts aligned
`timescale 1ns/1ps
module adcmt_clkdiv #(
  parameter int CNT_W = 6
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic run,
  input wire logic [2:0] div_code,
  // conversion clock tick
  output logic tick
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } adcmt_div_t;

  adcmt_div_t st;
  adcmt_div_t next_st;
  logic [CNT_W-1:0] last;

  assign last = CNT_W'(adcmt_pkg::div_ratio(div_code) - 6'd1);
  assign tick = run && (st.cnt == last);

  always_comb begin
    next_st = st;
    if (!run || st.cnt == last) begin
      next_st.cnt = '0;
    end else begin
      next_st.cnt = st.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  div_four_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && div_code == 3'h5) |=> !tick [*3])
    else $error("divide-by-4 ticked early");
  div_two_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && div_code == 3'h6) ##1 (run && div_code == 3'h6) |=> tick)
    else $error("divide-by-2 tick missing");

endmodule // adcmt_clkdiv

// ==== sim/adcmt_analog_model.sv ====
// adcmt_analog_model: analog code source and hardware trigger pulses
// assumes busy marks the span in which the converter core holds its code
`timescale 1ns/1ps
module adcmt_analog_model (
  // clock
  input wire logic aclk,
  // converter side
  input wire logic busy,
  output logic [7:0] code,
  // trigger sources
  output logic [3:0] trig
);
  logic [7:0] level = 8'h00;
  initial code = 8'h00;
  initial trig = 4'h0;
  // code is only steady while converting
  always @(posedge aclk) code <= busy ? level : ~code;
  task automatic fire(input int src);
    @(posedge aclk);
    trig[src] <= 1'b1;
    @(posedge aclk);
    trig[src] <= 1'b0;
  endtask
endmodule // adcmt_analog_model

// ==== sim/adcmt_ctrl_tb.sv ====
// adcmt_ctrl_tb: register and conversion tests of the converter control block
// assumes the analog model as far side and a 200 MHz aclk
`timescale 1ns/1ps
module adcmt_ctrl_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [5:0] awaddr = 6'h00;
  logic [5:0] araddr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, busy, busy_d, eirq, irq, hold, gate, scan, cmp;
  logic [1:0] bresp, rresp, rr;
  logic [31:0] rdata, rv;
  logic [3:0] trig;
  logic [7:0] code;
  int miscompares = 0;
  int comparisons = 0;
  int len, cnt;
  int ends = 0;
  int pulses = 0;
  // divider and mode choices the host is allowed at this clock
  logic [7:0] tm [11] = '{8'h81, 8'h89, 8'h91, 8'h99, 8'hA1, 8'hA9, 8'hB1, 8'hB9, 8'hBB,
    8'hBD, 8'hBF};
  int tot [11] = '{1316, 660, 332, 250, 209, 168, 86, 43, 82, 78, 225};
  always #2.5 aclk = ~aclk;
  adcmt_analog_model pm (.aclk(aclk), .busy(busy), .code(code), .trig(trig));
  adcmt_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timer_ch1_irq(trig[0]), .elc_event(trig[1]), .rtc_irq(trig[2]),
    .interval_timer_irq(trig[3]), .analog_code(code), .converter_reset_hold(hold),
    .converter_clock_gate(gate), .comparator_enable(cmp), .channel_select_mode(scan),
    .sample_active(), .conversion_busy(busy), .conversion_end_irq(eirq), .irq(irq));
  // busy span length and end pulse count
  always @(posedge aclk) begin
    busy_d <= busy;
    cnt <= (busy === 1'b1) ? ((busy_d === 1'b1) ? cnt + 1 : 1) : cnt;
    if (busy_d === 1'b1 && busy !== 1'b1) begin
      len <= cnt;
      ends <= ends + 1;
    end
    if (eirq === 1'b1) pulses <= pulses + 1;
  end
  task automatic tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic lost;
    miscompares++;
    tally_and_finish();
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    int t;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    t = 0;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      t++;
    end while (bvalid !== 1'b1 && t < 60);
    bready <= 1'b0;
    if (t >= 60) lost();
  endtask
  task automatic rd(input logic [5:0] a);
    int t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    t = 0;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      t++;
    end while (rvalid !== 1'b1 && t < 60);
    rv = rdata;
    rr = rresp;
    rready <= 1'b0;
    if (t >= 60) lost();
  endtask
  task automatic chk(input logic [5:0] a, input logic [31:0] exp, input string what);
    rd(a);
    check(what, rv, exp);
  endtask
  task automatic conv(input int exp, input string what);
    int e, t;
    e = ends;
    t = 0;
    while (ends == e && t < 3000) begin
      @(posedge aclk);
      t++;
    end
    if (t >= 3000) lost();
    check(what, len, exp);
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    chk(6'h14, 32'hFF, "upper limit");
    chk(6'h18, 32'h0, "lower limit");
    chk(6'h00, 32'h0, "reset control");
    rd(6'h28);
    check("unmapped resp", rr, 32'h2);
    wr(6'h04, 8'h20);
    check("clock gate", gate, 1'b1);
    wr(6'h08, 8'h40);
    check("scan mode", scan, 1'b1);
    wr(6'h00, 8'h20);
    check("hold out", hold, 1'b1);
    wr(6'h08, 8'h01);
    chk(6'h08, 32'h0, "timing under hold");
    check("select mode", scan, 1'b0);
    wr(6'h00, 8'h00);
    check("hold out", hold, 1'b0);
    $display("test registers done");
    pm.level = 8'h40;
    repeat (2000) @(posedge aclk);
    wr(6'h0C, 8'h20);
    wr(6'h14, 8'h5F);
    wr(6'h24, 8'h01);
    for (int i = 0; i < 11; i++) begin
      wr(6'h08, tm[i] & 8'h7F);
      check("comparator on", cmp, 1'b1);
      wr(6'h08, tm[i]);
      conv(tot[i], "conversion cycles");
    end
    chk(6'h1C, 32'h40, "result");
    check("end pulses", pulses, 32'd11);
    check("irq level", irq, 1'b1);
    wr(6'h20, 8'h01);
    check("irq cleared", irq, 1'b0);
    $display("test timing done");
    wr(6'h10, 8'h08);
    wr(6'h24, 8'h00);
    pm.level = 8'h60;
    wr(6'h08, 8'hB9);
    conv(43, "outside conversion");
    chk(6'h20, 32'h1, "outside hit");
    check("masked irq", irq, 1'b0);
    wr(6'h20, 8'h01);
    wr(6'h10, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(6'h0C, 8'hE0 | 8'(s));
      wr(6'h08, 8'hB9);
      pm.fire((s + 1) % 4);
      pm.fire(s);
      conv(43, "hw wait conversion");
    end
    wr(6'h0C, 8'hA0);
    wr(6'h08, 8'hB9);
    pm.fire(0);
    conv(41, "hw no-wait conversion");
    chk(6'h20, 32'h0, "no hit no overrun");
    check("end pulses", pulses, 32'd12);
    $display("test triggers done");
    tally_and_finish();
  end
endmodule // adcmt_ctrl_tb
